// >>> rtl/drive_input_pkg.sv
// Constants, types and behaviour list for the drive terminal input decoder.
// Behaviour
// - Enable open disables control, motor coasts.
// - Two-wire: forward or reverse held runs; open decels.
// - Fifteen-speed code n selects preset n+1.
// - All four selects closed: fault reset, no preset.
// - Group-select closed picks ramp group 2.
// - Enabled trip setting: open trip input trips.
// - Fan/pump: forward and reverse together reset fault.
// - Run-source input picks terminals or keypad control.
// - Source transfer keeps speed and direction.
// - Open fire override selects preset 1 first.
// - Closed fire, open freeze selects preset 2.
// - Overrides closed, speed source open: keypad speed.
// - Two-wire fan/pump: analog 1 or configured source.
// - Three-wire: momentary start closure latches run.
// - Three-wire: momentary stop opening ends run.
// - Two-wire modes: both directions asserted gives no motion.
// - Programmed operating mode selects decoding behaviour.
`default_nettype none

package drive_input_pkg;

    localparam int unsigned NUM_TERMINALS = 9;
    localparam int unsigned SYNC_STAGES   = 2;

    localparam int unsigned IN_ENABLE     = 0;
    localparam int unsigned IN_FORWARD    = 1;
    localparam int unsigned IN_REVERSE    = 2;
    localparam int unsigned IN_ANA_STOP   = 3;
    localparam int unsigned IN_RUN_SRC    = 4;
    localparam int unsigned IN_SPEED_SRC  = 5;
    localparam int unsigned IN_FIRE       = 6;
    localparam int unsigned IN_FREEZE     = 7;
    localparam int unsigned IN_TRIP       = 8;

    localparam logic [3:0] FAULT_RESET_CODE = 4'hF;
    localparam logic [3:0] PRESET_FIRE      = 4'h1;
    localparam logic [3:0] PRESET_FREEZE    = 4'h2;
    localparam logic [3:0] PRESET_RESET     = 4'h1;
    localparam logic [3:0] PRESET_STEP      = 4'h1;

    typedef enum logic [1:0] {
        MODE_PRESET15    = 2'b00,
        MODE_FAN_PUMP_2W = 2'b01,
        MODE_FAN_PUMP_3W = 2'b10,
        MODE_UNSUPPORTED = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_FWD  = 2'b01,
        RUN_REV  = 2'b10
    } run_state_t;

    typedef enum logic [1:0] {
        SRC_PRESET     = 2'b00,
        SRC_KEYPAD     = 2'b01,
        SRC_ANALOG1    = 2'b10,
        SRC_CMD_SOURCE = 2'b11
    } speed_src_t;

    localparam mode_t      MODE_RESET      = MODE_PRESET15;
    localparam speed_src_t SPEED_SRC_RESET = SRC_PRESET;

endpackage : drive_input_pkg

`default_nettype wire

// >>> rtl/terminal_sync.sv
// Two-stage synchroniser for the terminal input pins.
`default_nettype none

module terminal_sync #(
    parameter int unsigned WIDTH = 9
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule // terminal_sync

`default_nettype wire

// >>> rtl/drive_terminal_input_decoder.sv
// Terminal input decoder for the fifteen-speed and fan/pump operating modes.
`default_nettype none

module drive_terminal_input_decoder (
    input  wire logic                   ref_clk_i,
    input  wire logic                   reset_n_i,
    input  wire logic                   drive_enable_in_i,
    input  wire logic                   forward_run_in_i,
    input  wire logic                   reverse_run_in_i,
    input  wire logic                   analog_select_or_stop_in_i,
    input  wire logic                   run_cmd_source_in_i,
    input  wire logic                   speed_cmd_source_in_i,
    input  wire logic                   fire_override_in_i,
    input  wire logic                   freeze_override_in_i,
    input  wire logic                   ext_trip_in_i,
    input  wire drive_input_pkg::mode_t operating_mode_i,
    input  wire logic                   ext_trip_enable_i,
    input  wire logic                   keypad_start_fwd_i,
    input  wire logic                   keypad_start_rev_i,
    input  wire logic                   keypad_stop_i,
    input  wire logic                   keypad_fault_reset_i,
    output logic                        control_enable_o,
    output logic                        run_o,
    output logic                        reverse_o,
    output logic                        start_o,
    output logic                        fault_reset_o,
    output logic                        ext_trip_o,
    output logic                        ramp_group_select_o,
    output drive_input_pkg::speed_src_t speed_src_o,
    output logic [3:0]                  preset_index_o,
    output logic                        keypad_control_o,
    output logic                        source_transfer_o,
    output drive_input_pkg::mode_t      active_mode_o
);

    logic [drive_input_pkg::NUM_TERMINALS-1:0] term_raw;
    logic [drive_input_pkg::NUM_TERMINALS-1:0] term_sync;

    logic en_c;
    logic fwd_c;
    logic rev_c;
    logic ana_stop_c;
    logic run_src_c;
    logic speed_src_c;
    logic fire_c;
    logic freeze_c;
    logic trip_in_c;
    logic [3:0] code_c;

    drive_input_pkg::mode_t      mode_reg;
    drive_input_pkg::mode_t      mode_next;
    drive_input_pkg::run_state_t run_state_reg;
    drive_input_pkg::run_state_t run_state_next;
    drive_input_pkg::speed_src_t speed_src_reg;
    drive_input_pkg::speed_src_t speed_src_next;

    logic       fwd_prev_reg;
    logic       rev_prev_reg;
    logic       reset_cond_prev_reg;
    logic       run_src_prev_reg;
    logic       speed_src_prev_reg;
    logic       enable_reg;
    logic       enable_next;
    logic       run_reg;
    logic       run_next;
    logic       reverse_reg;
    logic       reverse_next;
    logic       start_reg;
    logic       start_next;
    logic       fault_reset_reg;
    logic       fault_reset_next;
    logic       trip_reg;
    logic       trip_next;
    logic       ramp_group_reg;
    logic       ramp_group_next;
    logic [3:0] preset_index_reg;
    logic [3:0] preset_index_next;
    logic       keypad_ctrl_reg;
    logic       keypad_ctrl_next;
    logic       transfer_reg;
    logic       transfer_next;

    logic reset_cond;
    logic fan_pump;
    logic terminal_ctrl;

    // Level-driven run decision shared by the two-wire modes.
    function automatic drive_input_pkg::run_state_t two_wire_state(
        input logic fwd,
        input logic rev
    );
        drive_input_pkg::run_state_t st;
        st = drive_input_pkg::RUN_IDLE;
        if (fwd && !rev) begin
            st = drive_input_pkg::RUN_FWD;
        end else if (rev && !fwd) begin
            st = drive_input_pkg::RUN_REV;
        end
        return st;
    endfunction

    assign term_raw[drive_input_pkg::IN_ENABLE]    = drive_enable_in_i;
    assign term_raw[drive_input_pkg::IN_FORWARD]   = forward_run_in_i;
    assign term_raw[drive_input_pkg::IN_REVERSE]   = reverse_run_in_i;
    assign term_raw[drive_input_pkg::IN_ANA_STOP]  = analog_select_or_stop_in_i;
    assign term_raw[drive_input_pkg::IN_RUN_SRC]   = run_cmd_source_in_i;
    assign term_raw[drive_input_pkg::IN_SPEED_SRC] = speed_cmd_source_in_i;
    assign term_raw[drive_input_pkg::IN_FIRE]      = fire_override_in_i;
    assign term_raw[drive_input_pkg::IN_FREEZE]    = freeze_override_in_i;
    assign term_raw[drive_input_pkg::IN_TRIP]      = ext_trip_in_i;

    terminal_sync #(
        .WIDTH (drive_input_pkg::NUM_TERMINALS)
    ) u_terminal_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (term_raw),
        .sync_o    (term_sync)
    );

    assign en_c        = term_sync[drive_input_pkg::IN_ENABLE];
    assign fwd_c       = term_sync[drive_input_pkg::IN_FORWARD];
    assign rev_c       = term_sync[drive_input_pkg::IN_REVERSE];
    assign ana_stop_c  = term_sync[drive_input_pkg::IN_ANA_STOP];
    assign run_src_c   = term_sync[drive_input_pkg::IN_RUN_SRC];
    assign speed_src_c = term_sync[drive_input_pkg::IN_SPEED_SRC];
    assign fire_c      = term_sync[drive_input_pkg::IN_FIRE];
    assign freeze_c    = term_sync[drive_input_pkg::IN_FREEZE];
    assign trip_in_c   = term_sync[drive_input_pkg::IN_TRIP];

    // first select input is the LSB
    assign code_c = {fire_c, speed_src_c, run_src_c, ana_stop_c};

    assign fan_pump = (mode_reg == drive_input_pkg::MODE_FAN_PUMP_2W) ||
                      (mode_reg == drive_input_pkg::MODE_FAN_PUMP_3W);

    assign terminal_ctrl = (mode_reg == drive_input_pkg::MODE_PRESET15) ||
                           (fan_pump && run_src_c);

    assign reset_cond = (mode_reg == drive_input_pkg::MODE_PRESET15) ?
                        (code_c == drive_input_pkg::FAULT_RESET_CODE) :
                        (fan_pump && fwd_c && rev_c);

    always_comb begin
        mode_next = (run_state_reg == drive_input_pkg::RUN_IDLE) ? operating_mode_i : mode_reg;

        trip_next = ext_trip_enable_i && !trip_in_c;

        enable_next = en_c;

        run_state_next = run_state_reg;
        if (!en_c || trip_next) begin
            run_state_next = drive_input_pkg::RUN_IDLE;
        end else begin
            case (mode_reg)
                drive_input_pkg::MODE_PRESET15: begin
                    run_state_next = two_wire_state(fwd_c, rev_c);
                end
                drive_input_pkg::MODE_FAN_PUMP_2W,
                drive_input_pkg::MODE_FAN_PUMP_3W: begin
                    if (!terminal_ctrl) begin
                        if (keypad_stop_i) begin
                            run_state_next = drive_input_pkg::RUN_IDLE;
                        end else if (keypad_start_fwd_i && !keypad_start_rev_i) begin
                            run_state_next = drive_input_pkg::RUN_FWD;
                        end else if (keypad_start_rev_i && !keypad_start_fwd_i) begin
                            run_state_next = drive_input_pkg::RUN_REV;
                        end
                    end else if (mode_reg == drive_input_pkg::MODE_FAN_PUMP_2W) begin
                        run_state_next = two_wire_state(fwd_c, rev_c);
                    end else begin
                        if (!ana_stop_c) begin
                            run_state_next = drive_input_pkg::RUN_IDLE;
                        end else if (fwd_c && !fwd_prev_reg && !rev_c) begin
                            run_state_next = drive_input_pkg::RUN_FWD;
                        end else if (rev_c && !rev_prev_reg && !fwd_c) begin
                            run_state_next = drive_input_pkg::RUN_REV;
                        end
                    end
                end
                default: begin
                    run_state_next = drive_input_pkg::RUN_IDLE;
                end
            endcase
        end

        run_next     = (run_state_next != drive_input_pkg::RUN_IDLE);
        reverse_next = (run_state_next == drive_input_pkg::RUN_REV);

        start_next = run_next && (run_state_next != run_state_reg);

        if (terminal_ctrl) begin
            fault_reset_next = reset_cond && !reset_cond_prev_reg;
        end else begin
            fault_reset_next = fan_pump && keypad_fault_reset_i;
        end

        speed_src_next    = speed_src_reg;
        preset_index_next = preset_index_reg;
        ramp_group_next   = 1'b0;
        case (mode_reg)
            drive_input_pkg::MODE_PRESET15: begin
                ramp_group_next = freeze_c;
                if (code_c != drive_input_pkg::FAULT_RESET_CODE) begin
                    speed_src_next    = drive_input_pkg::SRC_PRESET;
                    preset_index_next = code_c + drive_input_pkg::PRESET_STEP;
                end
            end
            drive_input_pkg::MODE_FAN_PUMP_2W,
            drive_input_pkg::MODE_FAN_PUMP_3W: begin
                if (!fire_c) begin
                    speed_src_next    = drive_input_pkg::SRC_PRESET;
                    preset_index_next = drive_input_pkg::PRESET_FIRE;
                end else if (!freeze_c) begin
                    speed_src_next    = drive_input_pkg::SRC_PRESET;
                    preset_index_next = drive_input_pkg::PRESET_FREEZE;
                end else if (!speed_src_c) begin
                    speed_src_next = drive_input_pkg::SRC_KEYPAD;
                end else if ((mode_reg == drive_input_pkg::MODE_FAN_PUMP_2W) && ana_stop_c) begin
                    speed_src_next = drive_input_pkg::SRC_ANALOG1;
                end else begin
                    speed_src_next = drive_input_pkg::SRC_CMD_SOURCE;
                end
            end
            default: begin
                speed_src_next = speed_src_reg;
            end
        endcase

        keypad_ctrl_next = fan_pump && !terminal_ctrl;

        transfer_next = fan_pump &&
                        ((run_src_c != run_src_prev_reg) || (speed_src_c != speed_src_prev_reg));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            mode_reg            <= drive_input_pkg::MODE_RESET;
            run_state_reg       <= drive_input_pkg::RUN_IDLE;
            speed_src_reg       <= drive_input_pkg::SPEED_SRC_RESET;
            preset_index_reg    <= drive_input_pkg::PRESET_RESET;
            fwd_prev_reg        <= 1'b0;
            rev_prev_reg        <= 1'b0;
            reset_cond_prev_reg <= 1'b0;
            run_src_prev_reg    <= 1'b0;
            speed_src_prev_reg  <= 1'b0;
            enable_reg          <= 1'b0;
            run_reg             <= 1'b0;
            reverse_reg         <= 1'b0;
            start_reg           <= 1'b0;
            fault_reset_reg     <= 1'b0;
            trip_reg            <= 1'b0;
            ramp_group_reg      <= 1'b0;
            keypad_ctrl_reg     <= 1'b0;
            transfer_reg        <= 1'b0;
        end else begin
            mode_reg            <= mode_next;
            run_state_reg       <= run_state_next;
            speed_src_reg       <= speed_src_next;
            preset_index_reg    <= preset_index_next;
            fwd_prev_reg        <= fwd_c;
            rev_prev_reg        <= rev_c;
            reset_cond_prev_reg <= reset_cond;
            run_src_prev_reg    <= run_src_c;
            speed_src_prev_reg  <= speed_src_c;
            enable_reg          <= enable_next;
            run_reg             <= run_next;
            reverse_reg         <= reverse_next;
            start_reg           <= start_next;
            fault_reset_reg     <= fault_reset_next;
            trip_reg            <= trip_next;
            ramp_group_reg      <= ramp_group_next;
            keypad_ctrl_reg     <= keypad_ctrl_next;
            transfer_reg        <= transfer_next;
        end
    end

    assign control_enable_o    = enable_reg;
    assign run_o               = run_reg;
    assign reverse_o           = reverse_reg;
    assign start_o             = start_reg;
    assign fault_reset_o       = fault_reset_reg;
    assign ext_trip_o          = trip_reg;
    assign ramp_group_select_o = ramp_group_reg;
    assign speed_src_o         = speed_src_reg;
    assign preset_index_o      = preset_index_reg;
    assign keypad_control_o    = keypad_ctrl_reg;
    assign source_transfer_o   = transfer_reg;
    assign active_mode_o       = mode_reg;

endmodule // drive_terminal_input_decoder

`default_nettype wire

// >>> dv/drive_terminal_input_decoder_asserts.sv
// Concurrent checks on the terminal input decoder ports.
`default_nettype none

module drive_terminal_input_decoder_asserts (
    input wire logic                        ref_clk_i,
    input wire logic                        reset_n_i,
    input wire logic                        drive_enable_in_i,
    input wire logic                        forward_run_in_i,
    input wire logic                        reverse_run_in_i,
    input wire logic                        fire_override_in_i,
    input wire logic                        ext_trip_in_i,
    input wire logic                        ext_trip_enable_i,
    input wire logic                        keypad_start_fwd_i,
    input wire logic                        keypad_start_rev_i,
    input wire logic                        keypad_stop_i,
    input wire logic                        keypad_fault_reset_i,
    input wire logic                        control_enable_o,
    input wire logic                        run_o,
    input wire logic                        start_o,
    input wire logic                        fault_reset_o,
    input wire logic                        ext_trip_o,
    input wire logic                        ramp_group_select_o,
    input wire logic                        keypad_control_o,
    input wire drive_input_pkg::mode_t      operating_mode_i,
    input wire drive_input_pkg::mode_t      active_mode_o,
    input wire drive_input_pkg::speed_src_t speed_src_o,
    input wire logic [3:0]                  preset_index_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_enable_open;
        !drive_enable_in_i [*4];
    endsequence
    sequence s_both_dirs;
        (forward_run_in_i && reverse_run_in_i) [*4];
    endsequence

    a_coast_on_open: assert property (s_enable_open |=> !control_enable_o && !run_o)
        else $error("control enabled while enable is open");
    a_both_no_run: assert property ((active_mode_o == drive_input_pkg::MODE_PRESET15)
        throughout s_both_dirs |=> !run_o) else $error("motion with both directions");
    a_trip_on_open: assert property ((ext_trip_enable_i && !ext_trip_in_i) [*4]
        |=> ext_trip_o && !run_o) else $error("open trip input not tripping");
    a_trip_ignored: assert property (!ext_trip_enable_i [*2] |=> !ext_trip_o)
        else $error("trip flagged while setting is off");
    a_start_single: assert property (start_o && !keypad_control_o |=> !start_o)
        else $error("start pulse longer than one cycle");
    a_reset_single: assert property (fault_reset_o && !keypad_fault_reset_i
        |=> !fault_reset_o) else $error("fault reset pulse longer than one cycle");
    a_group_fp_one: assert property ((active_mode_o != drive_input_pkg::MODE_PRESET15) [*2]
        |-> !ramp_group_select_o) else $error("ramp group 2 outside preset mode");
    a_fire_first: assert property ((active_mode_o[1] != active_mode_o[0]
        && !fire_override_in_i) [*5] |=> speed_src_o == drive_input_pkg::SRC_PRESET
        && preset_index_o == drive_input_pkg::PRESET_FIRE) else $error("fire preset missing");
    a_mode_frozen: assert property (run_o |=> $stable(active_mode_o))
        else $error("mode changed while running");
    a_mode_loaded: assert property (!run_o |=> active_mode_o == $past(operating_mode_i))
        else $error("mode not loaded while idle");
    a_keypad_start: assert property (keypad_control_o && keypad_start_fwd_i
        && !keypad_start_rev_i && !keypad_stop_i |=> run_o || !control_enable_o || ext_trip_o)
        else $error("keypad start ignored");
endmodule // drive_terminal_input_decoder_asserts

bind drive_terminal_input_decoder drive_terminal_input_decoder_asserts u_asserts (
    .ref_clk_i, .reset_n_i, .drive_enable_in_i, .forward_run_in_i, .reverse_run_in_i,
    .fire_override_in_i, .ext_trip_in_i, .ext_trip_enable_i, .keypad_start_fwd_i,
    .keypad_start_rev_i, .keypad_stop_i, .keypad_fault_reset_i, .control_enable_o, .run_o,
    .start_o, .fault_reset_o, .ext_trip_o, .ramp_group_select_o, .keypad_control_o,
    .operating_mode_i, .active_mode_o, .speed_src_o, .preset_index_o
);

`default_nettype wire

// >>> dv/terminal_panel.sv
// Switch panel model that drives the nine terminal inputs.
`default_nettype none

module terminal_panel (
    input  wire logic       ref_clk_i,
    input  wire logic [8:0] level_i,
    output logic      [8:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pins_o = 9'h000;
    // Contacts move between clock edges, 7 ns after the sampling edge.
    always @(posedge ref_clk_i) begin
        pins_o <= #7 level_i;
    end
endmodule // terminal_panel

`default_nettype wire

// >>> dv/drive_terminal_input_decoder_bench.sv
// Self-checking bench for the drive terminal input decoder.
`default_nettype none

module drive_terminal_input_decoder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                        ref_clk = 1'b0;
    logic                        reset_n = 1'b0;
    logic [8:0]                  level   = 9'h000;
    logic [8:0]                  pins;
    drive_input_pkg::mode_t      mode    = drive_input_pkg::MODE_PRESET15;
    logic                        trip_en = 1'b0;
    logic [3:0]                  kp      = 4'h0;
    logic                        ce, run, rev, start, fault, trip, group, kctl, xfer;
    drive_input_pkg::speed_src_t src;
    drive_input_pkg::mode_t      act;
    logic [3:0]                  idx;
    int                          cnt [3]  = '{0, 0, 0};
    int                          mark [3] = '{0, 0, 0};
    int                          cycles      = 0;
    int                          miscompares = 0;
    int                          cmp_count   = 0;

    terminal_panel u_panel (.ref_clk_i(ref_clk), .level_i(level), .pins_o(pins));

    drive_terminal_input_decoder u_dut (
        .ref_clk_i(ref_clk), .reset_n_i(reset_n), .drive_enable_in_i(pins[0]),
        .forward_run_in_i(pins[1]), .reverse_run_in_i(pins[2]),
        .analog_select_or_stop_in_i(pins[3]), .run_cmd_source_in_i(pins[4]),
        .speed_cmd_source_in_i(pins[5]), .fire_override_in_i(pins[6]),
        .freeze_override_in_i(pins[7]), .ext_trip_in_i(pins[8]), .operating_mode_i(mode),
        .ext_trip_enable_i(trip_en), .keypad_start_fwd_i(kp[0]), .keypad_start_rev_i(kp[1]),
        .keypad_stop_i(kp[2]), .keypad_fault_reset_i(kp[3]), .control_enable_o(ce),
        .run_o(run), .reverse_o(rev), .start_o(start), .fault_reset_o(fault),
        .ext_trip_o(trip), .ramp_group_select_o(group), .speed_src_o(src),
        .preset_index_o(idx), .keypad_control_o(kctl), .source_transfer_o(xfer),
        .active_mode_o(act)
    );

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cnt[0] <= cnt[0] + int'(start === 1'b1);
        cnt[1] <= cnt[1] + int'(fault === 1'b1);
        cnt[2] <= cnt[2] + int'(xfer === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end

    function automatic logic [8:0] pv(input logic fw, rv, ana, rs, ss, fi, fz);
        return {1'b1, fz, fi, ss, rs, ana, rv, fw, 1'b1};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic ev(input string what, input int k, input int d);
        check(what, 8'(cnt[k] - mark[k]), 8'(d));
        mark[k] = cnt[k];
    endtask

    task automatic set_pins(input logic [8:0] v);
        @(posedge ref_clk);
        level <= v;
        repeat (6) @(posedge ref_clk);
        #5;
    endtask

    task automatic key(input logic [3:0] k);
        @(posedge ref_clk);
        kp <= k;
        @(posedge ref_clk);
        kp <= 4'h0;
        repeat (3) @(posedge ref_clk);
        #5;
    endtask

    task automatic set_mode(input drive_input_pkg::mode_t m);
        @(posedge ref_clk);
        mode <= m;
        repeat (3) @(posedge ref_clk);
        #5;
    endtask

    task automatic fp_speed(input logic ana, ss, fi, fz, input logic [1:0] s, input int i);
        set_pins(pv(0, 0, ana, 1, ss, fi, fz));
        check("speed source", src, s);
        if (s == drive_input_pkg::SRC_PRESET) begin
            check("preset index", idx, 8'(i));
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        set_pins(pv(1, 0, 0, 0, 0, 0, 0));
        check("run", run, 1);
        check("reverse", rev, 0);
        check("control enable", ce, 1);
        ev("start", 0, 1);
        set_pins(pv(0, 1, 0, 0, 0, 0, 0));
        check("reverse", rev, 1);
        ev("start", 0, 1);
        set_pins(pv(1, 1, 0, 0, 0, 0, 0));
        check("run", run, 0);
        set_pins(pv(0, 0, 0, 0, 0, 0, 0));
        check("run", run, 0);
        for (int n = 0; n < 15; n++) begin
            set_pins(pv(0, 0, n[0], n[1], n[2], n[3], n[0]));
            check("preset index", idx, 8'(n + 1));
            check("speed source", src, drive_input_pkg::SRC_PRESET);
            check("ramp group", group, n[0]);
        end
        set_pins(pv(0, 0, 1, 1, 1, 1, 0));
        ev("fault reset", 1, 1);
        check("preset index", idx, 8'd15);
        $display("test preset speeds finished");
        @(posedge ref_clk);
        trip_en <= 1'b1;
        set_pins(pv(1, 0, 0, 0, 0, 0, 0) & 9'h0FF);
        check("ext trip", trip, 1);
        check("run", run, 0);
        set_pins(pv(1, 0, 0, 0, 0, 0, 0));
        check("ext trip", trip, 0);
        ev("start", 0, 1);
        @(posedge ref_clk);
        trip_en <= 1'b0;
        set_pins(pv(1, 0, 0, 0, 0, 0, 0) & 9'h0FF);
        check("ext trip", trip, 0);
        check("run", run, 1);
        set_pins(pv(1, 0, 0, 0, 0, 0, 0) & 9'h1FE);
        check("control enable", ce, 0);
        check("run", run, 0);
        set_pins(pv(1, 0, 0, 0, 0, 0, 0));
        ev("start", 0, 1);
        set_mode(drive_input_pkg::MODE_FAN_PUMP_2W);
        check("mode", act, drive_input_pkg::MODE_PRESET15);
        set_pins(pv(0, 0, 1, 1, 1, 1, 1));
        check("mode", act, drive_input_pkg::MODE_FAN_PUMP_2W);
        ev("fault reset", 1, 1);
        $display("test trip and enable finished");
        mark[2] = cnt[2];
        fp_speed(1, 1, 0, 0, drive_input_pkg::SRC_PRESET, 1);
        fp_speed(1, 1, 1, 0, drive_input_pkg::SRC_PRESET, 2);
        fp_speed(1, 0, 1, 1, drive_input_pkg::SRC_KEYPAD, 0);
        fp_speed(0, 1, 1, 1, drive_input_pkg::SRC_CMD_SOURCE, 0);
        fp_speed(1, 1, 1, 1, drive_input_pkg::SRC_ANALOG1, 0);
        ev("transfer", 2, 2);
        set_pins(pv(1, 1, 1, 1, 1, 1, 1));
        ev("fault reset", 1, 1);
        check("run", run, 0);
        set_pins(pv(1, 0, 1, 1, 1, 1, 1));
        check("run", run, 1);
        ev("start", 0, 1);
        set_pins(pv(1, 0, 1, 0, 1, 1, 1));
        check("keypad control", kctl, 1);
        check("run", run, 1);
        ev("transfer", 2, 1);
        key(4'h4);
        check("run", run, 0);
        key(4'h2);
        check("reverse", rev, 1);
        ev("start", 0, 1);
        key(4'h8);
        ev("fault reset", 1, 1);
        key(4'h1);
        check("reverse", rev, 0);
        ev("start", 0, 1);
        key(4'h3);
        ev("start", 0, 0);
        $display("test fan pump two wire finished");
        key(4'h4);
        set_pins(pv(0, 0, 1, 1, 1, 1, 1));
        set_mode(drive_input_pkg::MODE_FAN_PUMP_3W);
        check("mode", act, drive_input_pkg::MODE_FAN_PUMP_3W);
        for (int k = 0; k < 2; k++) begin
            set_pins(pv(1, 0, 1, 1, 1, 1, 1));
            set_pins(pv(0, 0, 1, 1, 1, 1, 1));
            check("run", run, 1);
            ev("start", 0, 1);
            set_pins(k == 0 ? pv(0, 0, 0, 1, 1, 1, 1) : pv(0, 0, 1, 1, 1, 1, 1) & 9'h1FE);
            set_pins(pv(0, 0, 1, 1, 1, 1, 1));
            check("run", run, 0);
        end
        set_pins(pv(1, 1, 1, 1, 1, 1, 1));
        ev("fault reset", 1, 1);
        check("run", run, 0);
        set_mode(drive_input_pkg::MODE_UNSUPPORTED);
        check("mode", act, drive_input_pkg::MODE_UNSUPPORTED);
        set_pins(pv(1, 0, 1, 1, 1, 1, 1));
        check("run", run, 0);
        check("keypad control", kctl, 0);
        $display("test fan pump three wire finished");
        report_and_stop();
    end
endmodule // drive_terminal_input_decoder_bench

`default_nettype wire
